// *** reset_strap_config_decoder_tb.sv ***
// self-checking testbench for the reset strap configuration decoder
`timescale 1ns/1ps
module reset_strap_config_decoder_tb;
   import rscd_pkg::*;
   logic clock, rst, scramble, reg_wr, reg_rd, cfg_locked;
   logic [3:0] reg_addr;
   logic [31:0] reg_wdata, reg_rdata, r, seed;
   logic [7:0] sw_pin_func;
   rscd_strap_t want, strap_pins, s;
   rscd_cfg_t cfg, e;
   rscd_pinctl_t pinctl, p;
   int fail_count, checks_done, it;
   rscd_board board (.clock(clock), .rst(rst), .want(want), .scramble(scramble),
      .strap_pins(strap_pins));
   rscd_decoder dut (.clock(clock), .rst(rst), .strap_pins(strap_pins), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .cfg(cfg), .pinctl(pinctl), .cfg_locked(cfg_locked), .sw_pin_func(sw_pin_func));
   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end
   function automatic rscd_cfg_t exp_cfg(rscd_strap_t t);
      logic ee;
      ee = t.autoinit_strap & t.pci_select & ~t.serial_port2_select;
      return {t.endian_select, t.boot_select, t.port_a_clock_select, t.port_b_clock_select,
         ee, ~ee, t.cell_port_enable, ~t.cell_port_enable, t.host_data_bit5_strap,
         (&t.boot_select) | (&t.port_a_clock_select) | (&t.port_b_clock_select)};
   endfunction
   function automatic rscd_pinctl_t exp_pin(rscd_strap_t t);
      return {t.cell_port_enable, ~t.cell_port_enable, t.host_data_bit5_strap};
   endfunction
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         fail_count++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge clock);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clock);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [31:0] exp);
      @(posedge clock);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clock);
      reg_rd <= 1'b0;
      #1 chk(reg_rdata, exp);
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checks_done, fail_count);
      if (fail_count == 0 && checks_done > 0) begin
         $display("No errors found");
      end else begin
         $display("Errors were found");
      end
      $finish;
   endtask
   initial begin
      #100000;
      fail_count++;
      close_out;
   end
   initial begin
      rst = 1'b1;
      scramble = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 4'h0;
      reg_wdata = 32'h0;
      want = 12'h000;
      seed = 32'h3231A0DC;
      fail_count = 0;
      checks_done = 0;
      for (it = 0; it < 12; it++) begin
         // every mid-run reset starts on a rising edge; the first one is held from time 0
         @(posedge clock);
         r = $random(seed);
         case (it)
            0: want <= 12'h000;
            1: want <= 12'hFFF;
            2: want <= 12'hCDE;
            3: want <= 12'h010;
            default: want <= r[11:0];
         endcase
         scramble <= 1'b0;
         rst <= 1'b1;
         repeat (16) @(posedge clock);
         #1 chk(cfg_locked, 1'b0);
         chk(sw_pin_func, RSCD_PINFUNC_RST);
         s = strap_pins;
         e = exp_cfg(s);
         p = exp_pin(s);
         @(posedge clock);
         rst <= 1'b0;
         repeat (5) @(posedge clock);
         #1 chk(cfg_locked, 1'b1);
         chk(cfg.little_endian, e.little_endian);
         chk(cfg.boot_mode, e.boot_mode);
         chk(cfg.port_a_clk_mode, e.port_a_clk_mode);
         chk(cfg.port_b_clk_mode, e.port_b_clk_mode);
         chk({cfg.pci_eeprom_init, cfg.pci_builtin_default}, {e.pci_eeprom_init,
            e.pci_builtin_default});
         chk(pinctl[2:1], p[2:1]);
         chk(cfg.cell_port_owns ^ cfg.serial_port1_owns, 1'b1);
         chk({cfg.host_port_32bit, pinctl.host_upper_oe_allow},
            {2{e.host_port_32bit}});
         chk(cfg.reserved_code, e.reserved_code);
         @(posedge clock);
         scramble <= 1'b1;
         repeat (6) @(posedge clock);
         #1 chk(cfg, e);
         chk(pinctl, p);
         rd(RSCD_OFS_STRAP, {20'h0, s});
         rd(RSCD_OFS_DECODE, {15'h0, p, e, 1'b1});
         wr(RSCD_OFS_PINFUNC, r);
         #1 chk(sw_pin_func, r[7:0]);
         rd(RSCD_OFS_PINFUNC, {24'h0, r[7:0]});
         wr(RSCD_OFS_STRAP, ~r);
         wr(RSCD_OFS_PINFUNC, ~r);
         rd(RSCD_OFS_STRAP, {20'h0, s});
         rd(RSCD_OFS_PINFUNC, {24'h0, ~r[7:0]});
         rd(4'hC, 32'h0);
      end
      close_out;
   end
endmodule // reset_strap_config_decoder_tb

// *** rscd_board.sv ***
// board model that holds the strap pins steady through reset
`timescale 1ns/1ps
module rscd_board
   import rscd_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire rscd_strap_t want,
   input wire logic scramble,
   output rscd_strap_t strap_pins
);
   // non-configuration address pins are never driven by this model
   logic [2:0] since_r;
   rscd_strap_t legal;
   always_comb begin
      legal = want;
      if (!want.pci_select) begin
         legal.autoinit_strap = 1'b0;
      end
   end
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         since_r <= 3'h0;
      end else if (since_r != 3'h7) begin
         since_r <= since_r + 3'h1;
      end
   end
   // once the hold window is over and scramble is set the straps toggle every cycle, nothing may follow them
   always_ff @(posedge clock) begin
      if (rst) begin
         strap_pins <= legal;
      end else if (scramble && since_r > 3'h4) begin
         strap_pins <= ~strap_pins;
      end
   end
endmodule // rscd_board

// *** rscd_decoder.sv ***
// reset strap capture and decode with register read back and software pin function register
`timescale 1ns/1ps
module rscd_decoder
   import rscd_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire rscd_strap_t strap_pins,
   input wire logic [RSCD_AW-1:0] reg_addr,
   input wire logic [RSCD_DW-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [RSCD_DW-1:0] reg_rdata,
   output rscd_cfg_t cfg,
   output rscd_pinctl_t pinctl,
   output logic cfg_locked,
   output logic [RSCD_PINFUNC_W-1:0] sw_pin_func
);

   // pin synchronisers carry no reset so they keep sampling while reset is held
   rscd_strap_t strap_meta_r;
   rscd_strap_t strap_sync_r;
   rscd_strap_t strap_cap_r;
   rscd_strap_t strap_cap_nxt;
   rscd_phase_t phase_r;
   rscd_phase_t phase_nxt;
   logic rst_meta_r;
   logic rst_sync_r;
   rscd_cfg_t cfg_r;
   rscd_cfg_t cfg_nxt;
   rscd_pinctl_t pinctl_r;
   rscd_pinctl_t pinctl_nxt;
   logic [RSCD_PINFUNC_W-1:0] pinfunc_r;
   logic [RSCD_PINFUNC_W-1:0] pinfunc_nxt;
   logic [RSCD_DW-1:0] rdata_r;
   logic [RSCD_DW-1:0] rdata_nxt;

   always_ff @(posedge clock) begin
      strap_meta_r <= strap_pins;
      strap_sync_r <= strap_meta_r;
   end

   // reset level seen on the clock, used to keep sampling until release is visible
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rst_meta_r <= 1'b1;
         rst_sync_r <= 1'b1;
      end else begin
         rst_meta_r <= 1'b0;
         rst_sync_r <= rst_meta_r;
      end
   end

   // capture phase lasts through reset and three edges after it, then freezes
   always_comb begin
      case (phase_r)
         RSCD_PH_CAPTURE: phase_nxt = rst_sync_r ? RSCD_PH_CAPTURE : RSCD_PH_LOCKED;
         RSCD_PH_LOCKED: phase_nxt = RSCD_PH_LOCKED;
         default: phase_nxt = RSCD_PH_CAPTURE;
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         phase_r <= RSCD_PH_CAPTURE;
      end else begin
         phase_r <= phase_nxt;
      end
   end

   wire capture_en = (phase_r == RSCD_PH_CAPTURE);
   assign strap_cap_nxt = capture_en ? strap_sync_r : strap_cap_r;

   // the captured copy has no reset: an async reset would wipe what reset is meant to sample
   always_ff @(posedge clock) begin
      strap_cap_r <= strap_cap_nxt;
   end

   // decode works only from the captured copy, never from live pins
   wire autoinit_pins_ok = strap_cap_r.pci_select & ~strap_cap_r.serial_port2_select;
   wire eeprom_init = strap_cap_r.autoinit_strap & autoinit_pins_ok;
   wire boot_rsvd = (strap_cap_r.boot_select == RSCD_BOOT_RSVD);
   wire a_rsvd = (strap_cap_r.port_a_clock_select == RSCD_CLK_RSVD);
   wire b_rsvd = (strap_cap_r.port_b_clock_select == RSCD_CLK_RSVD);
   wire cell_sel = strap_cap_r.cell_port_enable;

   always_comb begin
      cfg_nxt.little_endian = (strap_cap_r.endian_select == RSCD_ENDIAN_LITTLE);
      cfg_nxt.boot_mode = rscd_boot_t'(strap_cap_r.boot_select);
      cfg_nxt.port_a_clk_mode = rscd_clk_t'(strap_cap_r.port_a_clock_select);
      cfg_nxt.port_b_clk_mode = rscd_clk_t'(strap_cap_r.port_b_clock_select);
      cfg_nxt.pci_eeprom_init = eeprom_init;
      // default values whenever eeprom load is off or not permitted
      cfg_nxt.pci_builtin_default = ~eeprom_init;
      cfg_nxt.cell_port_owns = cell_sel;
      cfg_nxt.serial_port1_owns = ~cell_sel;
      cfg_nxt.host_port_32bit = strap_cap_r.host_data_bit5_strap;
      cfg_nxt.reserved_code = boot_rsvd | a_rsvd | b_rsvd;
   end

   always_comb begin
      pinctl_nxt.cell_dedicated_oe_allow = cell_sel;
      pinctl_nxt.serial1_dedicated_oe_allow = ~cell_sel;
      pinctl_nxt.host_upper_oe_allow = strap_cap_r.host_data_bit5_strap;
   end

   // decoded flops hold harmless defaults only while reset is held, then load the decode of the captured copy every edge
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         cfg_r <= '0;
         pinctl_r <= '0;
      end else begin
         cfg_r <= cfg_nxt;
         pinctl_r <= pinctl_nxt;
      end
   end

   // register port decode
   wire sel_strap = (reg_addr == RSCD_OFS_STRAP);
   wire sel_decode = (reg_addr == RSCD_OFS_DECODE);
   wire sel_pinfunc = (reg_addr == RSCD_OFS_PINFUNC);
   wire wr_pinfunc = reg_wr & sel_pinfunc;
   wire [RSCD_DW-1:0] strap_word = {{(RSCD_DW-$bits(rscd_strap_t)){1'b0}}, strap_cap_r};
   wire [RSCD_DW-1:0] decode_word = {{(RSCD_DW-RSCD_DEC_PIN_POS-$bits(rscd_pinctl_t)){1'b0}},
                                     pinctl_r, cfg_r, phase_r};
   wire [RSCD_DW-1:0] pinfunc_word = {{(RSCD_DW-RSCD_PINFUNC_W){1'b0}}, pinfunc_r};
   wire [RSCD_DW-1:0] read_mux = sel_strap ? strap_word :
                                 sel_decode ? decode_word :
                                 sel_pinfunc ? pinfunc_word : RSCD_RDATA_RST;

   // software pin function takes effect on the edge that takes the write
   assign pinfunc_nxt = wr_pinfunc ? reg_wdata[RSCD_PINFUNC_W-1:0] : pinfunc_r;
   // read data stand for one cycle only; unmapped offsets read zero
   assign rdata_nxt = reg_rd ? read_mux : RSCD_RDATA_RST;

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pinfunc_r <= RSCD_PINFUNC_RST;
         rdata_r <= RSCD_RDATA_RST;
      end else begin
         pinfunc_r <= pinfunc_nxt;
         rdata_r <= rdata_nxt;
      end
   end

   assign reg_rdata = rdata_r;
   assign cfg = cfg_r;
   assign pinctl = pinctl_r;
   assign cfg_locked = (phase_r == RSCD_PH_LOCKED);
   assign sw_pin_func = pinfunc_r;

   // helper: decode is settled once locked has stood for three edges
   logic [1:0] lock_age_r;
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lock_age_r <= 2'b00;
      end else if (cfg_locked && lock_age_r != 2'b11) begin
         lock_age_r <= lock_age_r + 2'b01;
      end
   end
   wire settled = (lock_age_r == 2'b11);

   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);

   chk_capture_frozen: assert property (
      cfg_locked ##1 cfg_locked |-> $stable(strap_cap_r) && $stable(cfg))
      else $error("captured straps changed after reset release");

   chk_endian_map: assert property (
      settled |-> cfg.little_endian == (strap_cap_r.endian_select == RSCD_ENDIAN_LITTLE))
      else $error("endian decode does not follow captured strap");

   chk_boot_map: assert property (
      settled |-> cfg.boot_mode == rscd_boot_t'(strap_cap_r.boot_select)
                  && (cfg.reserved_code || cfg.boot_mode != RSCD_BOOT_RSVD))
      else $error("boot mode decode wrong");

   chk_port_a_clk: assert property (
      settled |-> cfg.port_a_clk_mode == rscd_clk_t'(strap_cap_r.port_a_clock_select))
      else $error("port a clock mode decode wrong");

   chk_port_b_clk: assert property (
      settled |-> cfg.port_b_clk_mode == rscd_clk_t'(strap_cap_r.port_b_clock_select))
      else $error("port b clock mode decode wrong");

   chk_pci_default: assert property (
      settled && (!strap_cap_r.autoinit_strap || !strap_cap_r.pci_select
                  || strap_cap_r.serial_port2_select)
      |-> cfg.pci_builtin_default && !cfg.pci_eeprom_init)
      else $error("pci defaults not selected");

   chk_eeprom_init: assert property (
      settled && strap_cap_r.autoinit_strap && strap_cap_r.pci_select
      && !strap_cap_r.serial_port2_select |-> cfg.pci_eeprom_init && !cfg.pci_builtin_default)
      else $error("eeprom load not selected");

   chk_shared_owner: assert property (
      settled |-> $onehot({cfg.cell_port_owns, cfg.serial_port1_owns})
                  && cfg.cell_port_owns == strap_cap_r.cell_port_enable
                  && pinctl.cell_dedicated_oe_allow == cfg.cell_port_owns
                  && pinctl.serial1_dedicated_oe_allow == cfg.serial_port1_owns)
      else $error("shared pin ownership wrong");

   chk_host_width: assert property (
      settled |-> pinctl.host_upper_oe_allow == strap_cap_r.host_data_bit5_strap
                  && cfg.host_port_32bit == strap_cap_r.host_data_bit5_strap)
      else $error("host port width decode wrong");

   chk_pinfunc_write: assert property (
      reg_wr && reg_addr == RSCD_OFS_PINFUNC |=> sw_pin_func == $past(reg_wdata[7:0]))
      else $error("pin function did not follow write");

   chk_read_once: assert property (
      !reg_rd |=> reg_rdata == RSCD_RDATA_RST)
      else $error("read data present without read strobe");

   cov_host_boot: cover property (settled && cfg.boot_mode == RSCD_BOOT_HOST);
   cov_cell_owner: cover property (settled && cfg.cell_port_owns);
   cov_eeprom_load: cover property (settled && cfg.pci_eeprom_init);
   cov_pinfunc_rw: cover property (wr_pinfunc ##1 (reg_rd && sel_pinfunc));

endmodule // rscd_decoder

// *** rscd_pkg.sv ***
// package of constants and types for the reset strap configuration decoder
package rscd_pkg;

   // register port geometry
   localparam int RSCD_AW = 4;
   localparam int RSCD_DW = 32;

   // register byte offsets
   localparam logic [3:0] RSCD_OFS_STRAP = 4'h0;
   localparam logic [3:0] RSCD_OFS_DECODE = 4'h4;
   localparam logic [3:0] RSCD_OFS_PINFUNC = 4'h8;

   // software pin function register
   localparam int RSCD_PINFUNC_W = 8;
   localparam logic [7:0] RSCD_PINFUNC_RST = 8'h00;

   // field positions inside the decode status word
   localparam int RSCD_DEC_PHASE_POS = 0;
   localparam int RSCD_DEC_CFG_POS = 1;
   localparam int RSCD_DEC_PIN_POS = 14;

   // reset values of the register read path
   localparam logic [31:0] RSCD_RDATA_RST = 32'h0000_0000;

   // strap level meaning
   localparam logic RSCD_ENDIAN_BIG = 1'b0;
   localparam logic RSCD_ENDIAN_LITTLE = 1'b1;

   typedef enum logic [1:0] {
      RSCD_BOOT_NONE = 2'b00,
      RSCD_BOOT_HOST = 2'b01,
      RSCD_BOOT_ROM8 = 2'b10,
      RSCD_BOOT_RSVD = 2'b11
   } rscd_boot_t;

   typedef enum logic [1:0] {
      RSCD_CLK_EXT = 2'b00,
      RSCD_CLK_DIV4 = 2'b01,
      RSCD_CLK_DIV6 = 2'b10,
      RSCD_CLK_RSVD = 2'b11
   } rscd_clk_t;

   typedef enum logic {
      RSCD_PH_CAPTURE = 1'b0,
      RSCD_PH_LOCKED = 1'b1
   } rscd_phase_t;

   // strap levels as seen on the pins
   typedef struct packed {
      logic endian_select;
      logic [1:0] boot_select;
      logic [1:0] port_a_clock_select;
      logic [1:0] port_b_clock_select;
      logic autoinit_strap;
      logic cell_port_enable;
      logic host_data_bit5_strap;
      logic pci_select;
      logic serial_port2_select;
   } rscd_strap_t;

   // decoded static configuration
   typedef struct packed {
      logic little_endian;
      rscd_boot_t boot_mode;
      rscd_clk_t port_a_clk_mode;
      rscd_clk_t port_b_clk_mode;
      logic pci_eeprom_init;
      logic pci_builtin_default;
      logic cell_port_owns;
      logic serial_port1_owns;
      logic host_port_32bit;
      logic reserved_code;
   } rscd_cfg_t;

   // output enable permissions for pins owned by strap selection
   typedef struct packed {
      logic cell_dedicated_oe_allow;
      logic serial1_dedicated_oe_allow;
      logic host_upper_oe_allow;
   } rscd_pinctl_t;

endpackage
